/* testbench/adc_conversion_sequencer_properties.sv */
module adc_seq_checker (
  input wire logic                  clock,
  input wire logic                  rst_b,
  input wire logic [1:0]            host_start,
  input wire logic                  channel_group_select,
  input wire logic                  single_channel_mode,
  input wire logic [2:0]            single_channel,
  input wire logic [3:0]            start_delay,
  input wire logic                  pulse_enable,
  input wire adc_seq_pkg::channel_t mux_channel,
  input wire logic                  sample_enable,
  input wire logic                  conversion_pulse_output,
  input wire logic [1:0]            irq,
  input wire logic                  busy,
  input wire logic [23:0]           read_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_seq_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_idle_start;
    !busy && host_start != 2'b00;
  endsequence
  property p_pack;
    read_word[23:20] == 4'h0;
  endproperty
  a_pack: assert property (p_pack) else $error("pad bits set");
  property p_group;
    sample_enable |-> mux_channel[3] == channel_group_select;
  endproperty
  a_group: assert property (p_group) else $error("wrong group");
  property p_single;
    sample_enable && single_channel_mode |-> mux_channel[2:0] == single_channel;
  endproperty
  a_single: assert property (p_single) else $error("wrong channel");
  property p_start;
    host_start != 2'b00 |-> ##[1:3] busy;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_delay;
    s_idle_start ##0 start_delay != 4'h0 |=> !sample_enable [*8];
  endproperty
  a_delay: assert property (p_delay) else $error("delay skipped");
  property p_zero;
    s_idle_start ##0 start_delay == 4'h0 |-> ##[2:4] sample_enable;
  endproperty
  a_zero: assert property (p_zero) else $error("slow start");
  property p_pulse;
    !pulse_enable |-> !conversion_pulse_output;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse while off");
  property p_irq_busy;
    $rose(irq[0]) || $rose(irq[1]) |-> $past(busy) || $past(busy, 2) || $past(busy, 3);
  endproperty
  a_irq_busy: assert property (p_irq_busy) else $error("irq without series");
  property p_sample;
    sample_enable |-> busy;
  endproperty
  a_sample: assert property (p_sample) else $error("sampling while idle");
endmodule

bind adc_conversion_sequencer adc_seq_checker u_checker (
  .clock, .rst_b, .host_start, .channel_group_select, .single_channel_mode,
  .single_channel, .start_delay, .pulse_enable, .mux_channel, .sample_enable,
  .conversion_pulse_output, .irq, .busy, .read_word
);

/* testbench/analog_channel_model.sv */
module analog_channel_model (
  input  wire adc_seq_pkg::channel_t mux_channel,
  input  wire adc_seq_pkg::result_t  trial_code,
  input  wire adc_seq_pkg::result_t  offset,
  output logic                       comparator_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_seq_pkg::*;
  // Ideal comparator, each channel at its own level
  assign comparator_in = (offset + result_t'(mux_channel) * 10'h3B) >= trial_code;
endmodule

/* testbench/test_adc_conversion_sequencer.sv */
module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_seq_pkg::*;
  logic        clock, rst_b, external_convert_trigger, trigger_ignore, channel_group_select;
  logic        single_channel_mode, delay_between, pulse_enable, pulse_span_eight;
  logic        comparator_in, sample_enable, conversion_pulse_output, busy;
  logic [1:0]  host_start, host_trigger_owner, irq_clear, read_pair, irq;
  logic [2:0]  single_channel;
  logic [3:0]  start_delay;
  logic [7:0]  above_threshold;
  logic [23:0] read_word;
  logic [31:0] rng = 32'h20C20340;
  channel_t    mux_channel;
  result_t     threshold, offset, trial_code;
  int          fails = 0;
  int          comparisons = 0;
  logic        sample_seen = 1'b0;
  logic        pulse_seen = 1'b0;
  int          pulse_rises = 0;
  int          pulse_convs = 0;
  int          rises_base, convs_base;

  adc_conversion_sequencer u_dut (
    .clock, .rst_b, .external_convert_trigger, .host_start, .host_trigger_owner,
    .trigger_ignore, .channel_group_select, .single_channel_mode, .single_channel,
    .start_delay, .delay_between, .threshold, .pulse_enable, .pulse_span_eight,
    .irq_clear, .read_pair, .comparator_in, .mux_channel, .trial_code, .sample_enable,
    .conversion_pulse_output, .irq, .busy, .above_threshold, .read_word
  );
  analog_channel_model u_analog (.mux_channel, .trial_code, .offset, .comparator_in);

  always #10 clock = ~clock;

  // Counts pulse starts and conversions begun while the pulse is high
  always @(posedge clock) begin
    sample_seen <= sample_enable;
    pulse_seen  <= conversion_pulse_output;
    if (sample_enable && !sample_seen && conversion_pulse_output) begin
      pulse_convs <= pulse_convs + 1;
    end
    if (conversion_pulse_output && !pulse_seen) begin
      pulse_rises <= pulse_rises + 1;
    end
  end

  function logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function channel_t chan(input int i);
    return {channel_group_select, single_channel_mode ? single_channel : i[2:0]};
  endfunction
  function result_t level(input int i);
    return offset + result_t'(chan(i)) * 10'h3B;
  endfunction

  task tick(input int n = 1);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task check(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task complete_run();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task start(input logic [1:0] who);
    host_start = who;
    tick();
    host_start = 2'b00;
  endtask
  task pin_pulse();
    external_convert_trigger = 1'b1;
    tick(3);
    external_convert_trigger = 1'b0;
    tick(3);
  endtask
  task finish_series(input logic [1:0] who, input int limit);
    logic [7:0] above;
    int         n;
    n = 0;
    while ((irq & who) !== who && n < limit) begin
      tick();
      n++;
    end
    check("irq", who, irq);
    irq_clear = who;
    tick();
    irq_clear = 2'b00;
    tick();
    check("irq cleared", 24'h0, irq);
    for (int p = 0; p < 4; p++) begin
      read_pair = p[1:0];
      tick(2);
      check("read_word", {4'h0, level(2 * p + 1), level(2 * p)}, read_word);
    end
    for (int i = 0; i < 8; i++) above[i] = level(i) > threshold;
    check("above_threshold", above, above_threshold);
  endtask

  initial begin
    logic [31:0] r;
    {clock, rst_b, external_convert_trigger, trigger_ignore, channel_group_select} = '0;
    {single_channel_mode, delay_between, pulse_enable, pulse_span_eight} = '0;
    {host_start, host_trigger_owner, irq_clear, read_pair, single_channel} = '0;
    {start_delay, threshold, offset} = '0;
    tick(6);
    rst_b = 1'b1;
    tick();
    for (int k = 0; k < 12; k++) begin
      r = next_rand();
      {pulse_span_eight, pulse_enable, offset, threshold, single_channel} = r[24:0];
      {single_channel_mode, channel_group_select} = r[26:25];
      if (k == 0) threshold = level(0);
      rises_base = pulse_rises;
      convs_base = pulse_convs;
      start(r[27] ? 2'b10 : 2'b01);
      finish_series(r[27] ? 2'b10 : 2'b01, 400);
      check("pulse conversions", pulse_enable ? 24'h8 : 24'h0, pulse_convs - convs_base);
      check("pulse starts", pulse_enable ? (pulse_span_eight ? 24'h1 : 24'h2) : 24'h0,
            pulse_rises - rises_base);
    end
    $display("random series done");
    start(2'b11);
    finish_series(2'b11, 800);
    $display("queued series done");
    trigger_ignore = 1'b1;
    host_trigger_owner = 2'b10;
    pin_pulse();
    tick(20);
    check("busy", 24'h0, busy);
    trigger_ignore = 1'b0;
    pin_pulse();
    finish_series(2'b10, 400);
    $display("trigger series done");
    start_delay = 4'h1;
    start(2'b01);
    tick(24000);
    check("early irq", 24'h0, irq);
    finish_series(2'b01, 2000);
    $display("delayed series done");
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("unexpected watchdog: expected finish, seen hang");
    complete_run();
  end
endmodule

/* verilog/adc_conversion_sequencer.sv */
`include "adc_seq_map.svh"

module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  external_convert_trigger,
  input  wire logic [1:0]            host_start,
  input  wire logic [1:0]            host_trigger_owner,
  input  wire logic                  trigger_ignore,
  input  wire logic                  channel_group_select,
  input  wire logic                  single_channel_mode,
  input  wire logic [2:0]            single_channel,
  input  wire logic [3:0]            start_delay,
  input  wire logic                  delay_between,
  input  wire adc_seq_pkg::result_t  threshold,
  input  wire logic                  pulse_enable,
  input  wire logic                  pulse_span_eight,
  input  wire logic [1:0]            irq_clear,
  input  wire logic [1:0]            read_pair,
  input  wire logic                  comparator_in,
  output adc_seq_pkg::channel_t      mux_channel,
  output logic [9:0]                 trial_code,
  output logic                       sample_enable,
  output logic                       conversion_pulse_output,
  output logic [1:0]                 irq,
  output logic                       busy,
  output logic [7:0]                 above_threshold,
  output logic [23:0]                read_word
);
  import adc_seq_pkg::*;

  localparam int unsigned STEP_CYCLES = `DELAY_STEP_CYCLES;

  seq_state_t  state_q, state_d;
  logic [1:0]  pend_q, pend_d;
  logic [1:0]  owner_q, owner_d;
  logic        prio_q, prio_d;
  logic [2:0]  index_q, index_d;
  logic        group_q, group_d;
  logic        single_q, single_d;
  logic [2:0]  chan_q, chan_d;
  logic [3:0]  delay_q, delay_d;
  logic        between_q, between_d;
  result_t     thresh_q, thresh_d;
  logic        pulse_en_q, pulse_en_d;
  logic        span8_q, span8_d;
  logic [3:0]  steps_q, steps_d;
  logic [14:0] tick_q, tick_d;
  logic [1:0]  irq_q, irq_d;
  logic        pulse_q, pulse_d;
  result_t     store_q [8];
  result_t     store_d [8];
  logic [7:0]  above_q, above_d;
  logic [23:0] word_q, word_d;
  logic        sar_start;
  logic        sar_done;
  result_t     sar_result;
  logic        trig_rise;
  logic [1:0]  req_now;
  logic        tick_wrap;

  function automatic logic [1:0] pick_host(input logic [1:0] req, input logic prio);
    // Alternate priority between the two hosts when both wait
    if (req == 2'b11) begin
      pick_host = prio ? 2'b10 : 2'b01;
    end else if (req[0]) begin
      pick_host = 2'b01;
    end else begin
      pick_host = req & 2'b10;
    end
  endfunction

  trigger_sync u_trigger_sync (
    .clock (clock),
    .rst_b (rst_b),
    .pin   (external_convert_trigger),
    .rise  (trig_rise)
  );

  sar_engine u_sar_engine (
    .clock      (clock),
    .rst_b      (rst_b),
    .start      (sar_start),
    .comp_in    (comparator_in),
    .trial_code (trial_code),
    .busy       (sample_enable),
    .done       (sar_done),
    .result     (sar_result)
  );

  assign req_now   = host_start |
                     ((trig_rise && !trigger_ignore) ? host_trigger_owner : 2'b00);
  assign tick_wrap = (tick_q == 15'(STEP_CYCLES - 1));

  always_comb begin
    state_d    = state_q;
    pend_d     = pend_q | req_now;
    owner_d    = owner_q;
    prio_d     = prio_q;
    index_d    = index_q;
    group_d    = group_q;
    single_d   = single_q;
    chan_d     = chan_q;
    delay_d    = delay_q;
    between_d  = between_q;
    thresh_d   = thresh_q;
    pulse_en_d = pulse_en_q;
    span8_d    = span8_q;
    steps_d    = steps_q;
    tick_d     = 15'h0000;
    irq_d      = irq_q & ~irq_clear;
    pulse_d    = pulse_q;
    above_d    = above_q;
    store_d    = store_q;
    sar_start  = 1'b0;
    unique case (state_q)
      SEQ_IDLE: begin
        if (pend_q != 2'b00) begin
          owner_d    = pick_host(pend_q, prio_q);
          pend_d     = (pend_q & ~pick_host(pend_q, prio_q)) | req_now;
          prio_d     = ~prio_q;
          group_d    = channel_group_select;
          single_d   = single_channel_mode;
          chan_d     = single_channel;
          delay_d    = start_delay;
          between_d  = delay_between;
          thresh_d   = threshold;
          pulse_en_d = pulse_enable;
          span8_d    = pulse_span_eight;
          index_d    = 3'h0;
          steps_d    = start_delay;
          state_d    = SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        if (steps_q == 4'h0) begin
          sar_start = 1'b1;
          pulse_d   = pulse_en_q && (index_q == 3'h0 || index_q == 3'h4) ? 1'b1 : pulse_q;
          state_d   = SEQ_CONV;
        end else begin
          tick_d = tick_wrap ? 15'h0000 : tick_q + 15'h0001;
          if (tick_wrap) begin
            steps_d = steps_q - 4'h1;
          end
        end
      end
      SEQ_CONV: begin
        state_d = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (sar_done) begin
          store_d[index_q] = sar_result;
          above_d[index_q] = (sar_result > thresh_q);
          if (pulse_q && (index_q == 3'h3 && !span8_q || index_q == 3'h7)) begin
            pulse_d = 1'b0;
          end
          state_d = SEQ_STORE;
        end
      end
      SEQ_STORE: begin
        if (index_q == 3'h7) begin
          state_d = SEQ_DONE;
        end else begin
          index_d = index_q + 3'h1;
          steps_d = between_q ? delay_q : 4'h0;
          state_d = SEQ_DELAY;
        end
      end
      SEQ_DONE: begin
        // A clear from the other host in this cycle must still take effect
        irq_d   = irq_d | owner_q;
        owner_d = 2'b00;
        state_d = SEQ_IDLE;
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
  end

  // Two stored results per 24-bit word, lower index in the low half
  always_comb begin
    word_d = {4'h0, store_q[{read_pair, 1'b1}], store_q[{read_pair, 1'b0}]};
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= SEQ_IDLE;
      pend_q     <= 2'b00;
      owner_q    <= 2'b00;
      prio_q     <= 1'b0;
      index_q    <= 3'h0;
      group_q    <= 1'b0;
      single_q   <= 1'b0;
      chan_q     <= 3'h0;
      delay_q    <= 4'h0;
      between_q  <= 1'b0;
      thresh_q   <= `RESULT_RESET;
      pulse_en_q <= 1'b0;
      span8_q    <= 1'b0;
      steps_q    <= 4'h0;
      tick_q     <= 15'h0000;
      irq_q      <= 2'b00;
      pulse_q    <= 1'b0;
      above_q    <= 8'h00;
      word_q     <= 24'h000000;
      for (int i = 0; i < 8; i++) begin
        store_q[i] <= `RESULT_RESET;
      end
    end else begin
      state_q    <= state_d;
      pend_q     <= pend_d;
      owner_q    <= owner_d;
      prio_q     <= prio_d;
      index_q    <= index_d;
      group_q    <= group_d;
      single_q   <= single_d;
      chan_q     <= chan_d;
      delay_q    <= delay_d;
      between_q  <= between_d;
      thresh_q   <= thresh_d;
      pulse_en_q <= pulse_en_d;
      span8_q    <= span8_d;
      steps_q    <= steps_d;
      tick_q     <= tick_d;
      irq_q      <= irq_d;
      pulse_q    <= pulse_d;
      above_q    <= above_d;
      word_q     <= word_d;
      store_q    <= store_d;
    end
  end

  // Group select forms the top channel bit
  assign mux_channel             = {group_q, single_q ? chan_q : index_q};
  assign conversion_pulse_output = pulse_q;
  assign irq                     = irq_q;
  assign busy                    = (state_q != SEQ_IDLE);
  assign above_threshold         = above_q;
  assign read_word               = word_q;
endmodule

/* verilog/adc_seq_map.svh */
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define RESULT_WIDTH      10
`define SERIES_LENGTH     8
`define DELAY_WIDTH       4
`define DELAY_STEP_US     500
`define CLOCK_MHZ         50
`define DELAY_STEP_CYCLES (`DELAY_STEP_US * `CLOCK_MHZ)
`define DELAY_MAX_MS      8
`define SAR_BITS          10
`define SAR_SETTLE_CYCLES 2
`define RESULT_RESET      10'h000

`endif

/* verilog/adc_seq_pkg.sv */
package adc_seq_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b000,
    SEQ_DELAY  = 3'b001,
    SEQ_CONV   = 3'b010,
    SEQ_WAIT   = 3'b011,
    SEQ_STORE  = 3'b100,
    SEQ_DONE   = 3'b101
  } seq_state_t;

  typedef enum logic [1:0] {
    SAR_IDLE   = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_STEP   = 2'b10,
    SAR_DONE   = 2'b11
  } sar_state_t;

  typedef logic [9:0] result_t;
  typedef logic [3:0] channel_t;
endpackage

/* verilog/sar_engine.sv */
`include "adc_seq_map.svh"

module sar_engine
  import adc_seq_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                start,
  input  wire logic                comp_in,
  output logic [9:0]               trial_code,
  output logic                     busy,
  output logic                     done,
  output adc_seq_pkg::result_t     result
);
  sar_state_t state_q, state_d;
  logic [9:0] sar_q, sar_d;
  logic [9:0] bit_q, bit_d;
  logic [1:0] settle_q, settle_d;
  logic       done_q, done_d;

  always_comb begin
    state_d  = state_q;
    sar_d    = sar_q;
    bit_d    = bit_q;
    settle_d = settle_q;
    done_d   = 1'b0;
    unique case (state_q)
      SAR_IDLE: begin
        if (start) begin
          state_d  = SAR_SAMPLE;
          settle_d = 2'(`SAR_SETTLE_CYCLES - 1);
        end
      end
      SAR_SAMPLE: begin
        if (settle_q == 2'h0) begin
          state_d = SAR_STEP;
          bit_d   = 10'h200;
          sar_d   = 10'h200;
        end else begin
          settle_d = settle_q - 2'h1;
        end
      end
      SAR_STEP: begin
        // Keep the trial bit while the input stays above the trial level
        if (!comp_in) begin
          sar_d = sar_q & ~bit_q;
        end
        if (bit_q == 10'h001) begin
          state_d = SAR_DONE;
        end else begin
          sar_d = (comp_in ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
          bit_d = bit_q >> 1;
        end
      end
      SAR_DONE: begin
        done_d  = 1'b1;
        state_d = SAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= SAR_IDLE;
      sar_q    <= 10'h000;
      bit_q    <= 10'h000;
      settle_q <= 2'h0;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      sar_q    <= sar_d;
      bit_q    <= bit_d;
      settle_q <= settle_d;
      done_q   <= done_d;
    end
  end

  assign trial_code = sar_q;
  assign busy       = (state_q != SAR_IDLE);
  assign done       = done_q;
  assign result     = sar_q;
endmodule

/* verilog/trigger_sync.sv */
module trigger_sync (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      rise
);
  logic [2:0] sync_q, sync_d;
  logic       level_q, level_d;

  always_comb begin
    sync_d  = {sync_q[1:0], pin};
    level_d = level_q;
    // Accept a change only once the second and third stages agree
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  assign rise = level_d & ~level_q;
endmodule
